// *** ipf_top.sv ***
// Interrupt priority field registers with AHB-Lite slave
`timescale 1ns/1ps
`include "ipf_defs.svh"
module ipf_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Levels to arbitration
  output ipf_pkg::ipf_levels_s levels,
  output ipf_pkg::ipf_enables_s enables
);
  // Address phase capture
  logic wr_pend_q;
  logic [`IPF_ADDR_W-1:0] wr_addr_q;
  logic [31:0] hrdata_q;
  ipf_pkg::ipf_levels_s lv_q;
  ipf_pkg::ipf_enables_s en_q;
  logic hreadyout_q;
  logic hresp_q;

  wire addr_ok = hsel && hready && (htrans == `IPF_HTRANS_NONSEQ);
  wire [`IPF_ADDR_W-1:0] a_addr = haddr[`IPF_ADDR_W-1:0];
  wire wr_a = wr_pend_q && (wr_addr_q == `IPF_OFF_ADC_TX);
  wire wr_b = wr_pend_q && (wr_addr_q == `IPF_OFF_CHG_CMP);

  // Register read images, unused bits zero
  wire [15:0] adc_uart_tx_priority = {9'h000, lv_q.adc_done_priority, 1'h0,
                                      lv_q.serial_tx_priority};
  wire [15:0] change_compare_i2c_priority = {1'h0, lv_q.pin_change_priority, 1'h0,
                                             lv_q.comparator_priority, 1'h0,
                                             lv_q.twowire_controller_priority, 1'h0,
                                             lv_q.twowire_target_priority};
  wire [15:0] rd_sel = (a_addr == `IPF_OFF_ADC_TX) ? adc_uart_tx_priority :
                       (a_addr == `IPF_OFF_CHG_CMP) ? change_compare_i2c_priority : 16'h0000;

  // Next field values from write data
  ipf_pkg::ipf_levels_s lv_d;
  assign lv_d.adc_done_priority = wr_a ? hwdata[`IPF_ADC_LSB +: `IPF_PRIO_W] :
                                  lv_q.adc_done_priority;
  assign lv_d.serial_tx_priority = wr_a ? hwdata[`IPF_TX_LSB +: `IPF_PRIO_W] :
                                   lv_q.serial_tx_priority;
  assign lv_d.pin_change_priority = wr_b ? hwdata[`IPF_CHG_LSB +: `IPF_PRIO_W] :
                                    lv_q.pin_change_priority;
  assign lv_d.comparator_priority = wr_b ? hwdata[`IPF_CMP_LSB +: `IPF_PRIO_W] :
                                    lv_q.comparator_priority;
  assign lv_d.twowire_controller_priority = wr_b ? hwdata[`IPF_TWC_LSB +: `IPF_PRIO_W] :
                                            lv_q.twowire_controller_priority;
  assign lv_d.twowire_target_priority = wr_b ? hwdata[`IPF_TWT_LSB +: `IPF_PRIO_W] :
                                        lv_q.twowire_target_priority;

  // Zero level disables the source
  ipf_pkg::ipf_enables_s en_d;
  assign en_d.adc_done = lv_d.adc_done_priority != `IPF_PRIO_OFF;
  assign en_d.serial_tx = lv_d.serial_tx_priority != `IPF_PRIO_OFF;
  assign en_d.pin_change = lv_d.pin_change_priority != `IPF_PRIO_OFF;
  assign en_d.comparator = lv_d.comparator_priority != `IPF_PRIO_OFF;
  assign en_d.twowire_controller = lv_d.twowire_controller_priority != `IPF_PRIO_OFF;
  assign en_d.twowire_target = lv_d.twowire_target_priority != `IPF_PRIO_OFF;

  // Bus phase registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= a_addr;
      hrdata_q <= (addr_ok && !hwrite) ? {16'h0000, rd_sel} : 32'h00000000;
    end
  end

  // Priority fields, level passes unchanged
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lv_q <= {6{`IPF_PRIO_RST}};
      en_q <= '1;
    end else begin
      lv_q <= lv_d;
      en_q <= en_d;
    end
  end

  // Response registers, zero wait states and OKAY only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hreadyout_q <= 1'b1;
      hresp_q <= `IPF_RESP_OKAY;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= `IPF_RESP_OKAY;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign levels = lv_q;
  assign enables = en_q;

  // Check qualifiers
  wire rd_req = addr_ok && !hwrite;
  wire rd_hit_a = rd_req && (a_addr == `IPF_OFF_ADC_TX);
  wire rd_hit_b = rd_req && (a_addr == `IPF_OFF_CHG_CMP);
  wire rd_miss = rd_req && !rd_hit_a && !rd_hit_b;
  wire wr_miss = wr_pend_q && !wr_a && !wr_b;
  wire [`IPF_PRIO_W-1:0] cmp_wdata = hwdata[`IPF_CMP_LSB +: `IPF_PRIO_W];

  // Field writes
  property p_cmp_write;
    @(posedge core_clk) disable iff (!rst_n)
      wr_b |=> levels.comparator_priority == $past(cmp_wdata);
  endproperty
  a_cmp_write: assert property (p_cmp_write) else $error("comparator not written");

  property p_twt_write;
    @(posedge core_clk) disable iff (!rst_n)
      wr_b |=> levels.twowire_target_priority == $past(hwdata[`IPF_TWT_LSB +: `IPF_PRIO_W])
        && levels.pin_change_priority == $past(hwdata[`IPF_CHG_LSB +: `IPF_PRIO_W]);
  endproperty
  a_twt_write: assert property (p_twt_write) else $error("register two field wrong");

  property p_twc_write;
    @(posedge core_clk) disable iff (!rst_n)
      wr_b |=>
        levels.twowire_controller_priority == $past(hwdata[`IPF_TWC_LSB +: `IPF_PRIO_W]);
  endproperty
  a_twc_write: assert property (p_twc_write) else $error("controller not written");

  property p_adc_write;
    @(posedge core_clk) disable iff (!rst_n)
      wr_a |=> levels.adc_done_priority == $past(hwdata[`IPF_ADC_LSB +: `IPF_PRIO_W])
        && levels.serial_tx_priority == $past(hwdata[`IPF_TX_LSB +: `IPF_PRIO_W]);
  endproperty
  a_adc_write: assert property (p_adc_write) else $error("register one field wrong");

  property p_adc_max;
    @(posedge core_clk) disable iff (!rst_n)
      wr_a && hwdata[`IPF_ADC_LSB +: `IPF_PRIO_W] == `IPF_PRIO_MAX |=>
        levels.adc_done_priority == `IPF_PRIO_MAX && enables.adc_done;
  endproperty
  a_adc_max: assert property (p_adc_max) else $error("adc top level lost");

  // Level codes and enables
  property p_max_level;
    @(posedge core_clk) disable iff (!rst_n)
      wr_b && cmp_wdata == `IPF_PRIO_MAX |=>
        levels.comparator_priority == `IPF_PRIO_MAX && enables.comparator;
  endproperty
  a_max_level: assert property (p_max_level) else $error("comparator top level lost");

  property p_min_enable;
    @(posedge core_clk) disable iff (!rst_n)
      wr_b && cmp_wdata == `IPF_PRIO_MIN |=>
        levels.comparator_priority == `IPF_PRIO_MIN && enables.comparator;
  endproperty
  a_min_enable: assert property (p_min_enable) else $error("lowest level not enabled");

  property p_zero_disable;
    @(posedge core_clk) disable iff (!rst_n)
      wr_b && cmp_wdata == `IPF_PRIO_OFF |=> !enables.comparator;
  endproperty
  a_zero_disable: assert property (p_zero_disable) else $error("comparator still on");

  property p_twt_zero;
    @(posedge core_clk) disable iff (!rst_n)
      wr_b && hwdata[`IPF_TWT_LSB +: `IPF_PRIO_W] == `IPF_PRIO_OFF |=>
        !enables.twowire_target;
  endproperty
  a_twt_zero: assert property (p_twt_zero) else $error("target still on");

  property p_disable;
    @(posedge core_clk) disable iff (!rst_n)
      enables.comparator == (levels.comparator_priority != `IPF_PRIO_OFF);
  endproperty
  a_disable: assert property (p_disable) else $error("zero level not disabled");

  property p_en_adc;
    @(posedge core_clk) disable iff (!rst_n)
      enables.adc_done == (levels.adc_done_priority != `IPF_PRIO_OFF);
  endproperty
  a_en_adc: assert property (p_en_adc) else $error("adc enable wrong");

  property p_en_tx;
    @(posedge core_clk) disable iff (!rst_n)
      enables.serial_tx == (levels.serial_tx_priority != `IPF_PRIO_OFF);
  endproperty
  a_en_tx: assert property (p_en_tx) else $error("transmit enable wrong");

  property p_en_chg;
    @(posedge core_clk) disable iff (!rst_n)
      enables.pin_change == (levels.pin_change_priority != `IPF_PRIO_OFF);
  endproperty
  a_en_chg: assert property (p_en_chg) else $error("pin change enable wrong");

  property p_en_twc;
    @(posedge core_clk) disable iff (!rst_n)
      enables.twowire_controller == (levels.twowire_controller_priority != `IPF_PRIO_OFF);
  endproperty
  a_en_twc: assert property (p_en_twc) else $error("controller enable wrong");

  property p_en_twt;
    @(posedge core_clk) disable iff (!rst_n)
      enables.twowire_target == (levels.twowire_target_priority != `IPF_PRIO_OFF);
  endproperty
  a_en_twt: assert property (p_en_twt) else $error("target enable wrong");

  property p_level_hold;
    @(posedge core_clk) disable iff (!rst_n)
      !wr_pend_q |=> $stable(levels);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level changed without write");

  property p_miss_write;
    @(posedge core_clk) disable iff (!rst_n)
      wr_miss |=> $stable(levels);
  endproperty
  a_miss_write: assert property (p_miss_write) else $error("unmapped write landed");

  // Reset
  property p_reset_val;
    @(posedge core_clk) !rst_n |=> levels == {6{`IPF_PRIO_RST}} && enables == {6{1'h1}};
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("reset level not four");

  // Readback
  property p_read_zero_a;
    @(posedge core_clk) disable iff (!rst_n)
      rd_hit_a |=>
        (hrdata & `IPF_UNUSED_A) == 32'h00000000;
  endproperty
  a_read_zero_a: assert property (p_read_zero_a) else $error("unused bit reads one");

  property p_read_zero;
    @(posedge core_clk) disable iff (!rst_n)
      rd_hit_b |=>
        (hrdata & `IPF_UNUSED_B) == 32'h00000000;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unused bit reads one");

  property p_miss_read;
    @(posedge core_clk) disable iff (!rst_n)
      rd_miss |=> hrdata == 32'h00000000;
  endproperty
  a_miss_read: assert property (p_miss_read) else $error("unmapped read not zero");

  property p_data_idle;
    @(posedge core_clk) disable iff (!rst_n)
      !rd_req |=> hrdata == 32'h00000000;
  endproperty
  a_data_idle: assert property (p_data_idle) else $error("read data outside data phase");

  property p_adc_read;
    @(posedge core_clk) disable iff (!rst_n)
      rd_hit_a && !wr_pend_q |=>
        hrdata[`IPF_ADC_LSB +: `IPF_PRIO_W] == levels.adc_done_priority;
  endproperty
  a_adc_read: assert property (p_adc_read) else $error("adc readback wrong");

  property p_tx_read;
    @(posedge core_clk) disable iff (!rst_n)
      rd_hit_a && !wr_pend_q |=>
        hrdata[`IPF_TX_LSB +: `IPF_PRIO_W] == levels.serial_tx_priority;
  endproperty
  a_tx_read: assert property (p_tx_read) else $error("transmit readback wrong");

  property p_cmp_read;
    @(posedge core_clk) disable iff (!rst_n)
      rd_hit_b && !wr_pend_q |=>
        hrdata[`IPF_CMP_LSB +: `IPF_PRIO_W] == levels.comparator_priority;
  endproperty
  a_cmp_read: assert property (p_cmp_read) else $error("comparator readback wrong");

  property p_chg_read;
    @(posedge core_clk) disable iff (!rst_n)
      rd_hit_b && !wr_pend_q |=>
        hrdata[`IPF_CHG_LSB +: `IPF_PRIO_W] == levels.pin_change_priority;
  endproperty
  a_chg_read: assert property (p_chg_read) else $error("pin change readback wrong");

  property p_twc_read;
    @(posedge core_clk) disable iff (!rst_n)
      rd_hit_b && !wr_pend_q |=>
        hrdata[`IPF_TWC_LSB +: `IPF_PRIO_W] == levels.twowire_controller_priority;
  endproperty
  a_twc_read: assert property (p_twc_read) else $error("controller readback wrong");

  property p_twt_read;
    @(posedge core_clk) disable iff (!rst_n)
      rd_hit_b && !wr_pend_q |=>
        hrdata[`IPF_TWT_LSB +: `IPF_PRIO_W] == levels.twowire_target_priority;
  endproperty
  a_twt_read: assert property (p_twt_read) else $error("target readback wrong");

  // Scenario covers
  c_write_a: cover property (@(posedge core_clk) wr_a);
  c_write_b: cover property (@(posedge core_clk) wr_b);
  c_read_a: cover property (@(posedge core_clk) rd_hit_a && hsize == `IPF_HSIZE_WORD);
  c_read_b: cover property (@(posedge core_clk) rd_hit_b);
  c_disabled: cover property (@(posedge core_clk) !enables.comparator);
endmodule : ipf_top

// *** ipf_defs.svh ***
// Register offsets, field positions and reset values of the priority block
`ifndef IPF_DEFS_SVH
`define IPF_DEFS_SVH
`define IPF_ADDR_W 12
`define IPF_OFF_ADC_TX 12'h000
`define IPF_OFF_CHG_CMP 12'h004
`define IPF_PRIO_W 3
`define IPF_PRIO_RST 3'h4
`define IPF_PRIO_OFF 3'h0
`define IPF_PRIO_MAX 3'h7
`define IPF_PRIO_MIN 3'h1
`define IPF_ADC_LSB 4
`define IPF_TX_LSB 0
`define IPF_CHG_LSB 12
`define IPF_CMP_LSB 8
`define IPF_TWC_LSB 4
`define IPF_TWT_LSB 0
`define IPF_HTRANS_NONSEQ 2'h2
`define IPF_HSIZE_WORD 3'h2
`define IPF_RESP_OKAY 1'h0
`define IPF_UNUSED_A 32'hFFFF_FF88
`define IPF_UNUSED_B 32'hFFFF_8888
`endif

// *** ipf_pkg.sv ***
// Types shared by the priority block
package ipf_pkg;
  typedef logic [2:0] ipf_prio_t;
  typedef struct packed {
    ipf_prio_t adc_done_priority;
    ipf_prio_t serial_tx_priority;
    ipf_prio_t pin_change_priority;
    ipf_prio_t comparator_priority;
    ipf_prio_t twowire_controller_priority;
    ipf_prio_t twowire_target_priority;
  } ipf_levels_s;
  typedef struct packed {
    logic adc_done;
    logic serial_tx;
    logic pin_change;
    logic comparator;
    logic twowire_controller;
    logic twowire_target;
  } ipf_enables_s;
endpackage : ipf_pkg

// *** ipf_arb_model.sv ***
// Arbitration-side model: highest enabled priority level
`timescale 1ns/1ps
module ipf_arb_model (
  // Levels from the block
  input wire ipf_pkg::ipf_levels_s levels,
  input wire ipf_pkg::ipf_enables_s enables,
  // Winning level
  output logic [2:0] top_level
);
  logic [17:0] flat;
  assign flat = levels;
  always_comb begin
    top_level = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (enables[i] && flat[3*i+:3] > top_level) top_level = flat[3*i+:3];
    end
  end
endmodule : ipf_arb_model

// *** tb.sv ***
// Testbench for the priority field registers
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  ipf_pkg::ipf_levels_s levels;
  ipf_pkg::ipf_enables_s enables;
  logic [2:0] top_level;
  logic [31:0] rd;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #10 core_clk = ~core_clk;
  ipf_top ipf_top_inst (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .levels(levels), .enables(enables));
  ipf_arb_model ipf_arb_model_inst (.levels(levels), .enables(enables), .top_level(top_level));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic print_verdict;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 500) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk({14'h0, levels}, 32'h0002_4924);
    chk({26'h0, enables}, 32'h3F);
    xfer(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h44);
    xfer(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h4444);
    for (int v = 0; v < 8; v++) begin
      xfer(1'b1, 32'h4, 32'hFFFF_8888 | (32'(v) << 8) | (32'(v) << 4));
      xfer(1'b0, 32'h4, 32'h0);
      chk(rd, (32'(v) << 8) | (32'(v) << 4));
      chk({29'h0, levels.comparator_priority}, 32'(v));
      chk({29'h0, levels.twowire_controller_priority}, 32'(v));
      chk({26'h0, enables}, {26'h0, 2'h3, 1'b0, v != 0, v != 0, 1'b0});
      chk({29'h0, top_level}, (v > 4) ? 32'(v) : 32'h4);
    end
    xfer(1'b1, 32'h0, 32'hFFFF_FFFF);
    xfer(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h77);
    chk({29'h0, levels.adc_done_priority}, 32'h7);
    xfer(1'b1, 32'h4, 32'h0000_7531);
    xfer(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h7531);
    chk({26'h0, enables}, 32'h3F);
    chk({29'h0, top_level}, 32'h7);
    xfer(1'b1, 32'h8, 32'hFFFF_FFFF);
    xfer(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    chk({14'h0, levels}, 32'h0003_FF59);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk({14'h0, levels}, 32'h0002_4924);
    xfer(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h4444);
    print_verdict();
  end
endmodule : tb
